// [core/aop_defs.svh]
// constants of the over-range and power-profile register bank
//
// Contract
// - flag a channel whose sample magnitude reaches the programmed level
// - level code scales full scale as code/256; reset code 0xF2
// - four flags, channels a to d, sharing level and hold settings
// - enable bit 3 of config; while clear all four flags driven low
// - flag lasts at least 4*2^exponent cycles; exponent bits 2:0 reset 7
// - startup status bit 0 reads 1 once initialization has completed
// - profile b: 0x06 low power, 0x0F high performance, resets high performance
// - profile c: 0x00 low power, 0x04 high performance, resets high performance
`ifndef AOP_DEFS_SVH
`define AOP_DEFS_SVH

// serial frame: 1 direction bit, 15 address bits, 8 data bits
`define AOP_ADDR_W      15
`define AOP_DATA_W      8
`define AOP_HDR_BITS    16
`define AOP_CNT_W       5
`define AOP_RW_BIT      15

// register offsets
`define AOP_OFS_LEVEL   15'h0211
`define AOP_OFS_CFG     15'h0213
`define AOP_OFS_INIT    15'h0270
`define AOP_OFS_PROF_B  15'h029a
`define AOP_OFS_PROF_C  15'h029b
`define AOP_OFS_PROF_D  15'h029c

// reset values
`define AOP_RST_LEVEL   8'hf2
`define AOP_RST_CFG     4'h7
`define AOP_RST_PROF_B  8'h0f
`define AOP_RST_PROF_C  8'h04
`define AOP_RST_PROF_D  8'h1b

// config and startup status fields
`define AOP_CFG_W       4
`define AOP_CFG_EN_BIT  3
`define AOP_CFG_EXP_HI  2
`define AOP_EXP_W       3
`define AOP_INIT_BIT    0

// profile codes
`define AOP_PROF_B_LOW  8'h06
`define AOP_PROF_B_HIGH 8'h0f
`define AOP_PROF_C_LOW  8'h00
`define AOP_PROF_C_HIGH 8'h04
`define AOP_PROF_D_LOW  8'h14
`define AOP_PROF_D_HIGH 8'h1b

// over-range detection
`define AOP_LEVEL_W     8
`define AOP_HOLD_BASE   4
`define AOP_HOLD_W      10
`define AOP_NUM_CHAN    4

`endif

// [core/aop_pkg.sv]
// types of the over-range and power-profile register bank
package aop_pkg;
`include "aop_defs.svh"

  typedef enum logic [3:0] {
    AOP_SP_IDLE = 4'b0001,
    AOP_SP_HDR  = 4'b0010,
    AOP_SP_DATA = 4'b0100,
    AOP_SP_DONE = 4'b1000
  } aop_spi_state_t;

  typedef struct packed {
    logic [`AOP_HOLD_W-1:0] cnt;
    logic                   flag;
  } aop_chan_t;

  typedef struct packed {
    logic                   sclk_s1;
    logic                   sclk_s2;
    logic                   sclk_s3;
    logic                   cs_n_s1;
    logic                   cs_n_s2;
    logic                   sdi_s1;
    logic                   sdi_s2;
    aop_spi_state_t         state;
    logic [`AOP_CNT_W-1:0]  bit_cnt;
    logic [`AOP_HDR_BITS-1:0] shift;
    logic                   rd_op;
    logic [`AOP_ADDR_W-1:0] addr;
    logic [`AOP_DATA_W-1:0] rd_shift;
    logic                   sdo;
    logic [`AOP_DATA_W-1:0] level;
    logic [`AOP_CFG_W-1:0]  cfg;
    logic [`AOP_DATA_W-1:0] prof_b;
    logic [`AOP_DATA_W-1:0] prof_c;
    logic [`AOP_DATA_W-1:0] prof_d;
  } aop_main_t;

endpackage

// [core/aop_ovr_chan.sv]
// one channel of over-range detection with pulse extension
`timescale 1ns/10ps
`include "aop_defs.svh"
module aop_ovr_chan
  import aop_pkg::*;
#(
  parameter int SAMPLE_W = 12
) (
  input  wire logic                  clock_in,
  input  wire logic                  rst_n_in,
  input  wire logic [SAMPLE_W-1:0]   sample_in,
  input  wire logic [`AOP_LEVEL_W-1:0] level_code_in,
  input  wire logic [`AOP_EXP_W-1:0] hold_exp_in,
  input  wire logic                  enable_in,
  output logic                       flag_out
);

  aop_chan_t st_r;
  aop_chan_t st_nxt;

  // two's complement magnitude; the most negative code maps to full scale
  function automatic logic [SAMPLE_W-1:0] magnitude(input logic [SAMPLE_W-1:0] s);
    magnitude = s[SAMPLE_W-1] ? SAMPLE_W'(~s + 1'b1) : s;
  endfunction

  logic [SAMPLE_W-1:0]      level_abs;
  logic                     hit;
  logic [`AOP_HOLD_W-1:0]   hold_len;

  // level code is a fraction of full scale in 1/256 steps
  assign level_abs = SAMPLE_W'(level_code_in) << (SAMPLE_W - 1 - `AOP_LEVEL_W);
  assign hit       = magnitude(sample_in) >= level_abs;
  assign hold_len  = `AOP_HOLD_W'(`AOP_HOLD_BASE) << hold_exp_in;

  // counter runs even while gated so enabling mid-pulse shows the remainder
  always_comb begin
    st_nxt = st_r;
    if (hit) begin
      st_nxt.cnt = hold_len;
    end else if (st_r.cnt != '0) begin
      st_nxt.cnt = st_r.cnt - 1'b1;
    end
    // high for exactly hold_len cycles after the last hit
    st_nxt.flag = enable_in & (hit | (st_r.cnt > `AOP_HOLD_W'(1)));
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flag_out = st_r.flag;

endmodule // aop_ovr_chan

// [core/aop_bank.sv]
// over-range and power-profile register bank with serial register port
`timescale 1ns/10ps
`include "aop_defs.svh"
module aop_bank
  import aop_pkg::*;
#(
  parameter int SAMPLE_W = 12
) (
  input  wire logic                   clock_in,
  input  wire logic                   rst_n_in,
  input  wire logic                   spi_sclk_in,
  input  wire logic                   spi_cs_n_in,
  input  wire logic                   spi_sdi_in,
  output logic                        spi_sdo_out,
  output logic                        spi_sdo_oe_out,
  input  wire logic                   init_done_in,
  input  wire logic [SAMPLE_W-1:0]    sample_a_in,
  input  wire logic [SAMPLE_W-1:0]    sample_b_in,
  input  wire logic [SAMPLE_W-1:0]    sample_c_in,
  input  wire logic [SAMPLE_W-1:0]    sample_d_in,
  output logic                        overrange_flag_a_out,
  output logic                        overrange_flag_b_out,
  output logic                        overrange_flag_c_out,
  output logic                        overrange_flag_d_out,
  output logic [`AOP_DATA_W-1:0]      power_profile_b_out,
  output logic [`AOP_DATA_W-1:0]      power_profile_c_out,
  output logic [`AOP_DATA_W-1:0]      power_profile_d_out
);

  aop_main_t st_r;
  aop_main_t st_nxt;

  // register port in brief
  //   a frame is 24 serial clocks, msb first: direction, address, data
  //   direction 1 reads and 0 writes; one register per frame, no increment
  //   the pins are asynchronous to this clock, so each passes two flip-flops
  //   a third sclk stage turns the slow serial clock into edge strobes
  //   limitation: each sclk phase must last at least three clocks, or an
  //   edge is lost and every later bit of the frame lands one place off
  //   read data leave on synchronised falling edges, three clocks late,
  //   so the host still samples them cleanly on its next rising edge
  //   the read value is fetched at the end of the header, so a register
  //   that changes during the data phase reads as it was at that point
  //   a write lands only on the 24th rising edge; deselect before that
  //   abandons the frame with no side effect on any register
  //   the startup status bit is read live rather than latched
  //   there is no access gating by startup status: the host must wait
  //   the port polls every clock, trading some power for a design with
  //   one clock domain and no logic clocked by the serial clock

  // register map
  //   0x211  level code, 8 bits, read and write
  //   0x213  config: enable bit 3, hold exponent bits 2:0; bits 7:4 read 0
  //   0x270  startup status: bit 0 set once initialization has completed
  //   0x29a  profile b, 8 bits, any value stored
  //   0x29b  profile c, 8 bits, any value stored
  //   0x29c  profile d, 8 bits, any value stored

  logic                   sclk_rise;
  logic                   sclk_fall;
  logic [`AOP_HDR_BITS-1:0] hdr_word;
  logic [`AOP_DATA_W-1:0] wr_word;

  // read decode; unmapped offsets and reserved bits answer zero
  // a function so the fetch point can pass the live startup status
  // and the state copy without a second mux tree
  function automatic logic [`AOP_DATA_W-1:0] read_reg(input aop_main_t s,
                                                      input logic [`AOP_ADDR_W-1:0] a,
                                                      input logic init_done);
    read_reg = '0;
    unique case (a)
      `AOP_OFS_LEVEL:  read_reg = s.level;
      `AOP_OFS_CFG:    read_reg = `AOP_DATA_W'(s.cfg);
      `AOP_OFS_INIT:   read_reg[`AOP_INIT_BIT] = init_done;
      `AOP_OFS_PROF_B: read_reg = s.prof_b;
      `AOP_OFS_PROF_C: read_reg = s.prof_c;
      `AOP_OFS_PROF_D: read_reg = s.prof_d;
      default:         read_reg = '0;
    endcase
  endfunction

  // edges seen only on the second and third synchroniser stages
  // the first stage may be metastable, so nothing but the second reads it
  assign sclk_rise = st_r.sclk_s2 & ~st_r.sclk_s3;
  assign sclk_fall = ~st_r.sclk_s2 & st_r.sclk_s3;
  // shift views that already hold the bit arriving with this edge
  assign hdr_word  = {st_r.shift[`AOP_HDR_BITS-2:0], st_r.sdi_s2};
  assign wr_word   = {st_r.shift[`AOP_DATA_W-2:0], st_r.sdi_s2};

  // serial frame: direction, address, data, msb first; mode 0 timing
  always_comb begin
    st_nxt = st_r;
    // two flip-flops on every pin, a third on sclk for edge detection
    st_nxt.sclk_s1 = spi_sclk_in;
    st_nxt.sclk_s2 = st_r.sclk_s1;
    st_nxt.sclk_s3 = st_r.sclk_s2;
    st_nxt.cs_n_s1 = spi_cs_n_in;
    st_nxt.cs_n_s2 = st_r.cs_n_s1;
    st_nxt.sdi_s1  = spi_sdi_in;
    st_nxt.sdi_s2  = st_r.sdi_s1;
    // frame decode runs only while the synchronised select is low
    if (st_r.cs_n_s2) begin
      // deselect aborts any partial frame without side effects
      st_nxt.state   = AOP_SP_IDLE;
      st_nxt.bit_cnt = '0;
      st_nxt.sdo     = 1'b0;
    end else begin
      unique case (st_r.state)
        AOP_SP_IDLE: begin
          // selection seen: start counting header bits
          st_nxt.state   = AOP_SP_HDR;
          st_nxt.bit_cnt = '0;
        end
        AOP_SP_HDR: begin
          // direction and address shift in on each rising edge
          if (sclk_rise) begin
            st_nxt.shift   = hdr_word;
            st_nxt.bit_cnt = st_r.bit_cnt + 1'b1;
            if (st_r.bit_cnt == `AOP_CNT_W'(`AOP_HDR_BITS - 1)) begin
              st_nxt.rd_op    = hdr_word[`AOP_RW_BIT];
              st_nxt.addr     = hdr_word[`AOP_ADDR_W-1:0];
              // read data fetched here so the first falling edge can show bit 7
              st_nxt.rd_shift = read_reg(st_r, hdr_word[`AOP_ADDR_W-1:0], init_done_in);
              st_nxt.bit_cnt  = '0;
              st_nxt.state    = AOP_SP_DATA;
            end
          end
        end
        AOP_SP_DATA: begin
          // read data out on falls, write data in on rises
          if (sclk_fall) begin
            st_nxt.sdo      = st_r.rd_shift[`AOP_DATA_W-1];
            st_nxt.rd_shift = {st_r.rd_shift[`AOP_DATA_W-2:0], 1'b0};
          end
          if (sclk_rise) begin
            st_nxt.shift   = hdr_word;
            st_nxt.bit_cnt = st_r.bit_cnt + 1'b1;
            if (st_r.bit_cnt == `AOP_CNT_W'(`AOP_DATA_W - 1)) begin
              st_nxt.state = AOP_SP_DONE;
              if (!st_r.rd_op) begin
                // profile codes are stored as written; keeping to the defined
                // codes and moving all profiles together is left to the host
                // writes to read-only or unmapped offsets are dropped
                unique case (st_r.addr)
                  `AOP_OFS_LEVEL:  st_nxt.level  = wr_word;
                  `AOP_OFS_CFG:    st_nxt.cfg    = wr_word[`AOP_CFG_W-1:0];
                  `AOP_OFS_PROF_B: st_nxt.prof_b = wr_word;
                  `AOP_OFS_PROF_C: st_nxt.prof_c = wr_word;
                  `AOP_OFS_PROF_D: st_nxt.prof_d = wr_word;
                  default:         st_nxt.level  = st_r.level;
                endcase
              end
            end
          end
        end
        AOP_SP_DONE: begin
          // extra clocks in a frame are ignored until deselect
          if (sclk_fall) begin
            st_nxt.sdo = 1'b0;
          end
        end
      endcase
    end
  end

  // reset loads register defaults and a deselected, idle port
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      // select stages start high so no frame is seen as reset ends
      st_r         <= '0;
      st_r.cs_n_s1 <= 1'b1;
      st_r.cs_n_s2 <= 1'b1;
      st_r.state   <= AOP_SP_IDLE;
      st_r.level   <= `AOP_RST_LEVEL;
      st_r.cfg     <= `AOP_RST_CFG;
      st_r.prof_b  <= `AOP_RST_PROF_B;
      st_r.prof_c  <= `AOP_RST_PROF_C;
      st_r.prof_d  <= `AOP_RST_PROF_D;
    end else begin
      st_r <= st_nxt;
    end
  end

  // all outputs come from registers: these from the state register, the flags from the channel registers
  assign spi_sdo_out    = st_r.sdo;
  assign spi_sdo_oe_out = ~st_r.cs_n_s2;   // drive only while selected
  assign power_profile_b_out = st_r.prof_b;
  assign power_profile_c_out = st_r.prof_c;
  assign power_profile_d_out = st_r.prof_d;

  // four channels share one level and one hold setting; a change of
  // either reaches all channels on the same clock edge
  localparam int NUM_CHAN = `AOP_NUM_CHAN;
  logic [SAMPLE_W-1:0] samples [NUM_CHAN];
  logic [NUM_CHAN-1:0] flags;
  // sample ports gathered so one generate loop builds every channel
  assign samples[0] = sample_a_in;
  assign samples[1] = sample_b_in;
  assign samples[2] = sample_c_in;
  assign samples[3] = sample_d_in;

  for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
    // channel index ch maps a to 0 through d to 3
    aop_ovr_chan #(
      .SAMPLE_W (SAMPLE_W)
    ) u_chan (
      .clock_in      (clock_in),
      .rst_n_in      (rst_n_in),
      .sample_in     (samples[ch]),
      .level_code_in (st_r.level),
      .hold_exp_in   (st_r.cfg[`AOP_CFG_EXP_HI:0]),
      .enable_in     (st_r.cfg[`AOP_CFG_EN_BIT]),
      .flag_out      (flags[ch])
    );
  end

  // flag ports in channel order a to d
  assign overrange_flag_a_out = flags[0];
  assign overrange_flag_b_out = flags[1];
  assign overrange_flag_c_out = flags[2];
  assign overrange_flag_d_out = flags[3];

endmodule // aop_bank

// [verif/aop_bank_assertions.sv]
// port checker of the over-range and power-profile bank
`timescale 1ns/10ps
module aop_bank_assertions
  import aop_pkg::*;
#(
  parameter int SAMPLE_W = 12
) (
  input wire logic                clock_in,
  input wire logic                rst_n_in,
  input wire logic                spi_cs_n_in,
  input wire logic                spi_sdo_oe_out,
  input wire logic [SAMPLE_W-1:0] sample_a_in,
  input wire logic [SAMPLE_W-1:0] sample_b_in,
  input wire logic [SAMPLE_W-1:0] sample_c_in,
  input wire logic [SAMPLE_W-1:0] sample_d_in,
  input wire logic                overrange_flag_a_out,
  input wire logic                overrange_flag_b_out,
  input wire logic                overrange_flag_c_out,
  input wire logic                overrange_flag_d_out,
  input wire logic [7:0]          power_profile_b_out,
  input wire logic [7:0]          power_profile_c_out
);
  localparam logic [SAMPLE_W-1:0] SMAX = {1'b0, {(SAMPLE_W-1){1'b1}}};
  logic [9:0] same_r;
  // cycles with all four samples equal; 700 outlasts the longest hold of 512
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) same_r <= 10'h000;
    else if (sample_a_in != sample_b_in || sample_a_in != sample_c_in
             || sample_a_in != sample_d_in) same_r <= 10'h000;
    else if (same_r != 10'h2bc) same_r <= same_r + 10'h001;
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_held(f);
    f [*4];
  endsequence
  AST_FLAG_CAUSE: assert property ($rose(overrange_flag_a_out) |->
    $past(sample_a_in) != '0 || $past(sample_a_in, 2) != '0) else $error("flag a rose unprompted");
  AST_FLAG_SHARED: assert property (same_r == 10'h2bc |->
    {overrange_flag_b_out, overrange_flag_c_out, overrange_flag_d_out} == {3{overrange_flag_a_out}})
    else $error("flags differ on equal samples");
  AST_FLAG_RST_LOW: assert property ($rose(rst_n_in) |->
    ({overrange_flag_a_out, overrange_flag_b_out, overrange_flag_c_out,
      overrange_flag_d_out} == 4'h0) [*8]) else $error("flag high while disabled");
  AST_PULSE_A: assert property ($rose(overrange_flag_a_out) |-> s_held(overrange_flag_a_out))
    else $error("flag a pulse too short");
  AST_PULSE_B: assert property ($rose(overrange_flag_b_out) |-> s_held(overrange_flag_b_out))
    else $error("flag b pulse too short");
  AST_RESTART_D: assert property (overrange_flag_d_out && sample_d_in == SMAX |=>
    s_held(overrange_flag_d_out)) else $error("flag d not extended");
  AST_PROF_B_RST: assert property ($rose(rst_n_in) |-> power_profile_b_out == 8'h0f)
    else $error("profile b reset value");
  AST_PROF_C_RST: assert property ($rose(rst_n_in) |-> power_profile_c_out == 8'h04)
    else $error("profile c reset value");
  // data out is driven exactly while the select, two stages late, is low
  AST_OE_FOLLOWS_SEL: assert property (spi_sdo_oe_out == !$past(spi_cs_n_in, 2))
    else $error("data out enable does not follow select");
endmodule // aop_bank_assertions

bind aop_bank aop_bank_assertions #(.SAMPLE_W(SAMPLE_W)) u_aop_bank_assertions (
  .clock_in(clock_in), .rst_n_in(rst_n_in), .sample_a_in(sample_a_in),
  .spi_cs_n_in(spi_cs_n_in), .spi_sdo_oe_out(spi_sdo_oe_out),
  .sample_b_in(sample_b_in), .sample_c_in(sample_c_in), .sample_d_in(sample_d_in),
  .overrange_flag_a_out(overrange_flag_a_out), .overrange_flag_b_out(overrange_flag_b_out),
  .overrange_flag_c_out(overrange_flag_c_out), .overrange_flag_d_out(overrange_flag_d_out),
  .power_profile_b_out(power_profile_b_out), .power_profile_c_out(power_profile_c_out));

// [verif/aop_spi_host.sv]
// serial register host that sends whole 24-bit frames
`timescale 1ns/10ps
module aop_spi_host (
  input  wire logic clock_in,
  input  wire logic sdo_in,
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      sdi_out
);
  // idle: clock low between frames, select released
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out = 1'b0;
  end
  // one frame; half period hp kept at six or more so read data has settled
  task automatic xfer(input logic r, input logic [14:0] a, input logic [7:0] d,
                      input int hp, output logic [7:0] q);
    logic [23:0] f;
    f = {r, a, d};
    q = 8'h00;
    @(posedge clock_in);
    cs_n_out <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdi_out <= f[i];
      repeat (hp) @(posedge clock_in);
      sclk_out <= 1'b1;
      if (i < 8) q[i] = sdo_in;
      repeat (hp) @(posedge clock_in);
      sclk_out <= 1'b0;
    end
    sdi_out <= ~f[0];  // stale level never lingers on the data line
    repeat (hp + 4) @(posedge clock_in);
    cs_n_out <= 1'b1;
    repeat (4) @(posedge clock_in);
  endtask
endmodule // aop_spi_host

// [verif/aop_bank_test.sv]
// self-checking bench of the over-range and power-profile bank
`timescale 1ns/10ps
module aop_bank_test;
  logic        clock_in, rst_n_in, init_done_in, sclk, cs_n, sdi, sdo;
  logic [11:0] smp [4];
  logic [3:0]  flg;
  logic [7:0]  pb, pc, pd, rd;
  logic [31:0] rng = 32'hbe84;
  int          bad_count, check_count, mdl[int], p[4];
  aop_bank u_aop_bank (.clock_in(clock_in), .rst_n_in(rst_n_in), .spi_sclk_in(sclk),
    .spi_cs_n_in(cs_n), .spi_sdi_in(sdi), .spi_sdo_out(sdo), .spi_sdo_oe_out(),
    .init_done_in(init_done_in), .sample_a_in(smp[0]), .sample_b_in(smp[1]),
    .sample_c_in(smp[2]), .sample_d_in(smp[3]), .overrange_flag_a_out(flg[0]),
    .overrange_flag_b_out(flg[1]), .overrange_flag_c_out(flg[2]), .overrange_flag_d_out(flg[3]),
    .power_profile_b_out(pb), .power_profile_c_out(pc), .power_profile_d_out(pd));
  aop_spi_host u_aop_spi_host (.clock_in(clock_in), .sdo_in(sdo), .sclk_out(sclk),
    .cs_n_out(cs_n), .sdi_out(sdi));
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input int a, input int d);
    u_aop_spi_host.xfer(1'b0, 15'(a), 8'(d), 6 + int'(xs() % 4), rd);
    if (mdl.exists(a) && a != 15'h0270) mdl[a] = (a == 15'h0213) ? d & 15 : d;
  endtask
  task automatic rdk(input int a);
    u_aop_spi_host.xfer(1'b1, 15'(a), 8'h00, 6 + int'(xs() % 4), rd);
    chk("register", mdl.exists(a) ? 8'(mdl[a]) : 8'h00, rd);
  endtask
  // reference channels, stepping on the edge that samples the inputs
  always @(posedge clock_in) begin
    int s;
    for (int c = 0; c < 4; c++) begin
      s = $signed(smp[c]);
      if (s < 0) s = -s;
      if (!rst_n_in) p[c] = 0;
      else if (s >= mdl[15'h0211] * 8) p[c] = 4 << (mdl[15'h0213] & 7);
      else if (p[c] > 0) p[c]--;
    end
  end
  // md 0: independent random, 1: one value on all channels, 2: quiet
  task automatic run(input int n, input int md);
    logic [31:0] r;
    repeat (n) begin
      @(posedge clock_in);
      r = xs();
      for (int c = 0; c < 4; c++) begin
        if (md == 0) r = xs();
        smp[c] <= md == 2 ? 12'h000 : r[2:0] == 0 ? r[15:4] : r[2:0] == 1 ? 12'h7ff : r[23:16];
      end
      #1;
      for (int c = 0; c < 4; c++)
        chk("flag", 8'((mdl[15'h0213] & 8) != 0 && p[c] > 0), 8'(flg[c]));
    end
  endtask
  initial begin
    repeat (100000) @(posedge clock_in);
    bad_count++;
    end_sim();
  end
  initial begin
    rst_n_in = 1'b0;
    init_done_in = 1'b0;
    for (int c = 0; c < 4; c++) smp[c] = 12'h000;
    mdl[15'h0211] = 8'hf2;
    mdl[15'h0213] = 8'h07;
    mdl[15'h0270] = 8'h01;
    mdl[15'h029a] = 8'h0f;
    mdl[15'h029b] = 8'h04;
    mdl[15'h029c] = 8'h1b;
    repeat (12) @(posedge clock_in);
    rst_n_in <= 1'b1;
    repeat (20) @(posedge clock_in);
    init_done_in <= 1'b1;
    repeat (3) @(posedge clock_in);  // no access before init completes
    foreach (mdl[a]) rdk(a);
    rdk(15'h0212);
    $display("test reset values done");
    // both profiles, all registers moved together
    // samples are judged only after the last profile write, as after calibration
    for (int m = 0; m < 2; m++) begin
      wr(15'h029a, m ? 8'h0f : 8'h06);
      wr(15'h029b, m ? 8'h04 : 8'h00);
      wr(15'h029c, m ? 8'h1b : 8'h14);
      chk("profile b", 8'(mdl[15'h029a]), pb);
      chk("profile c", 8'(mdl[15'h029b]), pc);
      chk("profile d", 8'(mdl[15'h029c]), pd);
      rdk(15'h029a);
      rdk(15'h029b);
    end
    wr(15'h0270, 8'h00);
    wr(15'h0212, 8'h55);
    rdk(15'h0270);
    rdk(15'h0212);
    $display("test profiles done");
    for (int e = 0; e < 3; e++) begin
      wr(15'h0211, 8'h40 + int'(xs() % 176));
      wr(15'h0213, 8'h08 + 3 * e);  // reserved bits written zero
      rdk(15'h0213);
      run(400, 0);
      run(800, 1);
      run(600, 2);
    end
    wr(15'h0213, 8'h02);
    run(300, 0);
    $display("test over-range done");
    end_sim();
  end
endmodule // aop_bank_test
